// ---- core/mode_smoother_map.svh ----
// Constants for the mode transition smoother: timing figures and counts.
// Assumes the includer works at 125 MHz and with 16-bit samples.
`ifndef MODE_SMOOTHER_MAP_SVH
`define MODE_SMOOTHER_MAP_SVH
// ==========================================================
// Timing figures, in microseconds times 10 (0.1 us units)
`define POSTFILTER_DELAY_US4   32'h0000_09C4
`define XFADE_END_8K_US4       32'h0000_30D4
`define XFADE_END_OTHER_US4    32'h0000_5A55
`define OUT_FRAME_US4          32'h0003_0D40
// Overlap length per core rate: 0.00125 * rate = rate_hz / 800
`define OVERLAP_DIVISOR        32'h0000_0320
`define RATE_8K_HZ             32'h0000_1F40
// ==========================================================
// Counts
`define LPC_ORDER              5'h10
`define ZIR_LEN                7'h40
`define ZIR_LAST               6'h3F
`define FRAC_BITS              5'h0F
`endif

// ---- core/mode_smoother_pkg.sv ----
// Types shared by the mode transition smoother.
// Assumes nothing beyond a SystemVerilog compiler.
package mode_smoother_pkg;
	// ==========================================================
	// Coding modes and transition variants
	typedef enum logic [1:0] {
		predictive_mode,
		transform_excitation_mode,
		high_quality_transform_mode
	} coding_mode_e;
	typedef enum logic [1:0] {
		no_transition,
		reset_transition_variant,
		dual_rate_transition_variant,
		mixed_transition_variant
	} variant_e;
	// Frame-start information
	typedef struct packed {
		coding_mode_e cur_mode;
		coding_mode_e prev_mode;
		variant_e     variant;
		logic         out_rate_8k;
	} frame_info_s;
	// One input sample set, all core/output signals of one time step but the high band
	typedef struct packed {
		logic signed [15:0] transform;
		logic signed [15:0] predictive;
		logic signed [15:0] prev_transform;
		logic signed [15:0] aliased_mem;
	} sample_in_s;
	// Commands to the cores for each transition variant and the predictive-to-transform switch
	typedef struct packed {
		logic zero_memories;
		logic load_fixed_coeffs;
		logic force_transition_coding;
		logic single_coeff_set;
		logic dual_rate_update;
		logic extrapolate_memories;
		logic lengthen_transform;
		logic dual_inverse_transform;
		logic zero_pad_low_rate;
	} core_cmd_s;
endpackage

// ---- core/mode_transition_smoother.sv ----
// Per-frame transition smoother between predictive and transform cores.
// Assumes the cores stream aligned samples and issue frame_start first.
// Behaviour
// - Reset transition zeroes resampler, emphasis, synthesis, excitation, postfilter memories.
// - Reset transition loads fixed coefficients, spectral pairs and gain memories.
// - Reset transition forces transition coding without the past adaptive codebook.
// - Reset transition uses one end-of-frame coefficient set for all subframes.
// - First D samples take previous transform synthesis, then aliased memory is added.
// - No window compensation on high-quality transform signal before overlap-add.
// - Dual-rate variant updates core and resampler memories from core-rate transform.
// - Transform alone, then linear blend, then predictive alone.
// - Cross-fade end is 1.25ms at 8kHz output, else 2.3125ms.
// - Cross-fade lies within a 20ms output frame at output rate.
// - Variant chosen per bitrate and previous mode governs update and fade.
// - Mixed variant resets or extrapolates, then fades like the reset variant.
// - Predictive-to-transform-excitation switch lengthens frame and runs two inverse transforms.
// - Overlap length is 0.00125 times the core sample rate.
// - Modified predictive signal overlap-adds transform with mirrored-window aliasing terms.
// - Filter state is last 16 difference samples, order-16 last-subframe coefficients.
// - Zero-input recursion yields 64 response samples.
// - Response sample n scaled by (64-n)/64.
// - Windowed response added to first 64 core-rate transform samples.
// - Output-rate response is linear interpolation of core-rate response.
// - High-band transition signal overlaps gap and cross-fades with transform.
// - Transform decoder also makes low-rate output, zero-padding when needed.
`include "mode_smoother_map.svh"
module mode_transition_smoother #(
	parameter int CORE_RATE_HZ = 12800,
	parameter int OUT_RATE_HZ  = 16000,
	parameter int GAP_LEN      = 64
) (
	input  wire logic                           clk_sys_i,
	input  wire logic                           reset_i,
	input  wire logic                           frame_start_i,
	input  wire mode_smoother_pkg::frame_info_s info_i,
	input  wire logic signed [15:0]             coeff_i [16],
	input  wire logic                           hist_valid_i,
	input  wire logic signed [15:0]             hist_orig_i,
	input  wire logic signed [15:0]             hist_mod_i,
	input  wire logic                           core_valid_i,
	input  wire logic signed [15:0]             core_sample_i,
	output logic                                core_ready_o,
	output logic                                core_valid_o,
	output logic signed [15:0]                  core_sample_o,
	input  wire logic                           out_valid_i,
	input  wire mode_smoother_pkg::sample_in_s  out_sample_i,
	input  wire logic signed [15:0]             highband_i,
	output logic                                out_ready_o,
	output logic                                out_valid_o,
	output logic signed [15:0]                  out_sample_o,
	output mode_smoother_pkg::core_cmd_s        core_cmd_o,
	output logic [15:0]                         overlap_len_o,
	output logic                                zir_busy_o
);
	// ==========================================================
	// Derived sample counts (rate * time)
	localparam int US4_PER_S = 10000000;
	localparam longint OR = OUT_RATE_HZ;
	localparam int POSTFILTER_DELAY = int'((OR * `POSTFILTER_DELAY_US4) / US4_PER_S);
	localparam int END_8K = int'((OR * `XFADE_END_8K_US4) / US4_PER_S);
	localparam int END_OT = int'((OR * `XFADE_END_OTHER_US4) / US4_PER_S);
	localparam int N_OUT = int'((OR * `OUT_FRAME_US4) / US4_PER_S);
	localparam int N_T = CORE_RATE_HZ / `OVERLAP_DIVISOR;
	// Interpolation step core/out in Q15 (precomputed, no divider)
	localparam int STEP_Q = int'((longint'(CORE_RATE_HZ) <<< 15) / OR);

	// Blend weight lookup: reciprocal of fade length, constant
	function automatic logic [15:0] recip_q15(input int len);
		recip_q15 = (len > 0) ? 16'(32768 / len) : 16'h0000;
	endfunction
	// Q15 multiply with saturation-free truncation
	function automatic logic signed [15:0] mul_q15(
		input logic signed [15:0] a, input logic signed [16:0] w);
		logic signed [33:0] p;
		p = a * w;
		mul_q15 = p[30:15];
	endfunction
	// Saturating add of two samples
	function automatic logic signed [15:0] sat_add(
		input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s > 17'sd32767)
			sat_add = 16'sh7FFF;
		else if (s < -17'sd32768)
			sat_add = -16'sh7FFF - 16'sh0001;
		else
			sat_add = s[15:0];
	endfunction

	// ==========================================================
	// Frame information latched at frame start
	mode_smoother_pkg::frame_info_s info_reg;
	logic [15:0]                    out_idx_reg;
	logic [6:0]                     core_idx_reg;
	logic [15:0]                    fade_end;
	logic [15:0]                    fade_rcp;
	logic                           to_pred;
	logic                           to_trans;
	assign to_pred = info_reg.prev_mode != mode_smoother_pkg::predictive_mode
		&& info_reg.cur_mode == mode_smoother_pkg::predictive_mode;
	assign to_trans = info_reg.prev_mode == mode_smoother_pkg::predictive_mode
		&& info_reg.cur_mode == mode_smoother_pkg::transform_excitation_mode;
	assign fade_end = info_reg.out_rate_8k ? 16'(END_8K) : 16'(END_OT);
	assign fade_rcp = info_reg.out_rate_8k ? recip_q15(END_8K - POSTFILTER_DELAY)
		: recip_q15(END_OT - POSTFILTER_DELAY);
	assign overlap_len_o = 16'(N_T);

	// Commands to the cores, held for the whole frame
	always_comb begin
		core_cmd_o = '0;
		if (to_pred) begin
			case (info_reg.variant)
			mode_smoother_pkg::reset_transition_variant: begin
				core_cmd_o.zero_memories = 1'b1;
				core_cmd_o.load_fixed_coeffs = 1'b1;
				core_cmd_o.force_transition_coding = 1'b1;
				core_cmd_o.single_coeff_set = 1'b1;
			end
			mode_smoother_pkg::dual_rate_transition_variant: begin
				core_cmd_o.dual_rate_update = 1'b1;
				core_cmd_o.zero_pad_low_rate = OUT_RATE_HZ < CORE_RATE_HZ;
			end
			mode_smoother_pkg::mixed_transition_variant: begin
				core_cmd_o.zero_memories = 1'b1;
				core_cmd_o.extrapolate_memories = 1'b1;
			end
			default: begin
			end
			endcase
		end
		if (to_trans) begin
			core_cmd_o.lengthen_transform = 1'b1;
			core_cmd_o.dual_inverse_transform = 1'b1;
		end
	end

	// ==========================================================
	// Zero-input response engine
	typedef enum {zir_idle, zir_load, zir_run, zir_done} zir_state_e;
	zir_state_e         zir_reg;
	zir_state_e         zir_next;
	logic signed [15:0] mem_reg [16];
	logic signed [15:0] zir_buf [64];
	logic [6:0]         zir_cnt_reg;
	logic signed [15:0] diff;
	logic signed [15:0] zir_new;
	logic signed [31:0] acc;
	logic signed [16:0] win_w;
	// Modified signal arrives from the core; only the difference is kept
	assign diff = hist_orig_i - hist_mod_i;
	assign win_w = 17'(32'(`ZIR_LEN - zir_cnt_reg) <<< 9); // (64-n)/64 Q15

	// All-pole recursion over the last 16 outputs
	always_comb begin
		acc = '0;
		for (int m = 0; m < 16; m++)
			acc = acc - coeff_i[m] * mem_reg[m];
		zir_new = acc[27:12];
	end

	always_comb begin
		zir_next = zir_reg;
		case (zir_reg)
		zir_idle:
			if (frame_start_i && info_i.prev_mode
				== mode_smoother_pkg::predictive_mode
				&& info_i.cur_mode
				== mode_smoother_pkg::transform_excitation_mode)
				zir_next = zir_load;
		zir_load:
			if (zir_cnt_reg == 7'(`LPC_ORDER))
				zir_next = zir_run;
		zir_run:
			if (zir_cnt_reg == 7'(`ZIR_LAST))
				zir_next = zir_done;
		zir_done:
			if (frame_start_i)
				zir_next = zir_idle;
		default:
			zir_next = zir_idle;
		endcase
	end
	assign zir_busy_o = zir_reg == zir_load || zir_reg == zir_run;

	// Shift history or response into filter state; buffer windowed output
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			zir_reg <= zir_idle;
			zir_cnt_reg <= '0;
			for (int i = 0; i < 16; i++)
				mem_reg[i] <= '0;
		end else begin
			zir_reg <= zir_next;
			if (zir_next != zir_reg)
				zir_cnt_reg <= '0;
			else if ((zir_reg == zir_load && hist_valid_i)
				|| zir_reg == zir_run)
				zir_cnt_reg <= zir_cnt_reg + 7'h01;
			if (zir_reg == zir_load && hist_valid_i) begin
				mem_reg[0] <= diff;
				for (int i = 1; i < 16; i++)
					mem_reg[i] <= mem_reg[i-1];
			end else if (zir_reg == zir_run) begin
				mem_reg[0] <= zir_new;
				for (int i = 1; i < 16; i++)
					mem_reg[i] <= mem_reg[i-1];
			end
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (zir_reg == zir_run)
			zir_buf[zir_cnt_reg[5:0]] <= mul_q15(zir_new, win_w);
	end

	// ==========================================================
	// Core-rate path: add windowed response to first 64 samples
	assign core_ready_o = !zir_busy_o;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			core_valid_o <= 1'b0;
			core_sample_o <= '0;
			core_idx_reg <= '0;
		end else begin
			core_valid_o <= core_valid_i && core_ready_o;
			if (frame_start_i)
				core_idx_reg <= '0;
			else if (core_valid_i && core_ready_o) begin
				if (to_trans && zir_reg == zir_done
					&& core_idx_reg < `ZIR_LEN) begin
					core_sample_o <= sat_add(core_sample_i,
						zir_buf[core_idx_reg[5:0]]);
					core_idx_reg <= core_idx_reg + 7'h01;
				end else
					core_sample_o <= core_sample_i;
			end
		end
	end

	// ==========================================================
	// Output-rate path: cross-fades and resampled response
	logic [31:0]        pos_q;
	logic [5:0]         pos_i;
	logic [5:0]         pos_n;
	logic signed [16:0] frac;
	logic signed [15:0] zir_interp;
	logic signed [16:0] w_pred;
	logic signed [15:0] faded;
	logic signed [15:0] out_next;
	assign pos_q = 32'(out_idx_reg) * 32'(STEP_Q);
	assign pos_i = pos_q[20:15];
	assign pos_n = (pos_i == 6'(`ZIR_LAST)) ? pos_i : pos_i + 6'h01;
	assign frac = {2'b00, pos_q[14:0]};
	assign zir_interp = sat_add(mul_q15(zir_buf[pos_i], 17'sh08000 - frac),
		mul_q15(zir_buf[pos_n], frac));
	assign w_pred = 17'(32'(out_idx_reg - 16'(POSTFILTER_DELAY)) * 32'(fade_rcp));
	assign faded = sat_add(mul_q15(out_sample_i.transform, 17'sh08000
		- w_pred), mul_q15(out_sample_i.predictive, w_pred));

	// Per-sample selection by transition and position in frame
	always_comb begin
		out_next = out_sample_i.predictive;
		if (to_pred && out_idx_reg < 16'(N_OUT)) begin
			case (info_reg.variant)
			mode_smoother_pkg::dual_rate_transition_variant:
				if (out_idx_reg < 16'(POSTFILTER_DELAY))
					out_next = out_sample_i.transform;
				else if (out_idx_reg < fade_end)
					out_next = faded;
			mode_smoother_pkg::reset_transition_variant,
			mode_smoother_pkg::mixed_transition_variant:
				// Raw synthesis, no window compensation
				if (out_idx_reg < 16'(POSTFILTER_DELAY))
					out_next = out_sample_i.prev_transform;
				else
					out_next = sat_add(out_sample_i.predictive,
						out_sample_i.aliased_mem);
			default:
				out_next = out_sample_i.predictive;
			endcase
		end else if (to_trans) begin
			out_next = out_sample_i.transform;
			if (zir_reg == zir_done && pos_i < 6'(`ZIR_LAST)
				&& pos_q[31:21] == '0)
				out_next = sat_add(out_next, zir_interp);
			if (out_idx_reg < 16'(GAP_LEN))
				out_next = sat_add(out_next, highband_i);
			else if (out_idx_reg < 16'(2 * GAP_LEN))
				out_next = sat_add(out_next, mul_q15(highband_i,
					17'(32'(16'(2 * GAP_LEN) - out_idx_reg)
					* 32'(recip_q15(GAP_LEN)))));
		end else if (info_reg.cur_mode != mode_smoother_pkg::predictive_mode)
			out_next = out_sample_i.transform;
	end

	assign out_ready_o = !zir_busy_o;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			info_reg <= '0;
			out_idx_reg <= '0;
			out_valid_o <= 1'b0;
			out_sample_o <= '0;
		end else begin
			out_valid_o <= out_valid_i && out_ready_o;
			if (frame_start_i) begin
				info_reg <= info_i;
				out_idx_reg <= '0;
			end else if (out_valid_i && out_ready_o) begin
				out_sample_o <= out_next;
				out_idx_reg <= out_idx_reg + 16'h0001;
			end
		end
	end
endmodule

// ---- verification/mode_smoother_chk.sv ----
// Port-level assertions for the transition smoother.
// Assumes a bind onto mode_transition_smoother, one clock domain.
module mode_smoother_chk #(
	parameter int CORE_RATE_HZ = 12800
) (
	input wire logic                           clk_sys_i,
	input wire logic                           reset_i,
	input wire logic                           frame_start_i,
	input wire mode_smoother_pkg::frame_info_s info_i,
	input wire logic                           core_valid_i,
	input wire logic                           core_ready_o,
	input wire logic                           core_valid_o,
	input wire logic                           out_valid_i,
	input wire logic                           out_ready_o,
	input wire logic                           out_valid_o,
	input wire mode_smoother_pkg::core_cmd_s   core_cmd_o,
	input wire logic [15:0]                    overlap_len_o,
	input wire logic                           zir_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// ====
	// Frame-start decode
	logic p2t;
	logic fs_rst;
	logic fs_dual;
	logic fs_mix;
	assign p2t = frame_start_i
		&& info_i.cur_mode == mode_smoother_pkg::transform_excitation_mode
		&& info_i.prev_mode == mode_smoother_pkg::predictive_mode;
	assign fs_rst = frame_start_i
		&& info_i.variant == mode_smoother_pkg::reset_transition_variant;
	assign fs_dual = frame_start_i
		&& info_i.variant == mode_smoother_pkg::dual_rate_transition_variant;
	assign fs_mix = frame_start_i
		&& info_i.variant == mode_smoother_pkg::mixed_transition_variant;
	// ====
	// Handshake and command checks
	property p_ready; core_ready_o == !zir_busy_o; endproperty
	a_ready: assert property (p_ready) else $error("ready not !busy");
	property p_core_lat; core_valid_i && core_ready_o |=> core_valid_o;
	endproperty
	a_core_lat: assert property (p_core_lat) else $error("core lat");
	property p_core_idle; !(core_valid_i && core_ready_o) |=> !core_valid_o;
	endproperty
	a_core_idle: assert property (p_core_idle) else $error("core idle");
	property p_out_lat; out_valid_i && out_ready_o |=> out_valid_o; endproperty
	a_out_lat: assert property (p_out_lat) else $error("out lat");
	property p_overlap; overlap_len_o == 16'(CORE_RATE_HZ / 800); endproperty
	a_overlap: assert property (p_overlap) else $error("overlap");
	property p_zir; p2t |=> zir_busy_o [*8]; endproperty
	a_zir: assert property (p_zir) else $error("zir busy");
	property p_p2t; p2t |=> core_cmd_o.lengthen_transform
		&& core_cmd_o.dual_inverse_transform; endproperty
	a_p2t: assert property (p_p2t) else $error("p2t cmd");
	property p_rst; fs_rst |=> core_cmd_o.zero_memories
		&& core_cmd_o.load_fixed_coeffs && core_cmd_o.force_transition_coding
		&& core_cmd_o.single_coeff_set; endproperty
	a_rst: assert property (p_rst) else $error("reset cmd");
	property p_dual; fs_dual |=> core_cmd_o.dual_rate_update; endproperty
	a_dual: assert property (p_dual) else $error("dual cmd");
	property p_mix; fs_mix |=> core_cmd_o.zero_memories
		&& core_cmd_o.extrapolate_memories; endproperty
	a_mix: assert property (p_mix) else $error("mixed cmd");
	property p_hold; !frame_start_i |=> $stable(core_cmd_o); endproperty
	a_hold: assert property (p_hold) else $error("cmd moved");
endmodule

// ---- verification/core_src_model.sv ----
// Behavioural model of the cores feeding the core-rate side.
// Assumes go_i is pulsed after a frame start; one clock domain.
module core_src_model #(
	parameter logic signed [15:0] ORIG  = 16'h0140,
	parameter logic signed [15:0] MODV  = 16'h0100,
	parameter logic signed [15:0] BASE  = 16'h0300,
	parameter int                 COUNT = 70
) (
	input  wire logic               clk_sys_i,
	input  wire logic               go_i,
	input  wire logic               core_ready_i,
	output logic                    hist_valid_o,
	output logic signed [15:0]      hist_orig_o,
	output logic signed [15:0]      hist_mod_o,
	output logic                    core_valid_o,
	output logic signed [15:0]      core_sample_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle values at time zero
	initial begin
		hist_valid_o = 1'b0;
		hist_orig_o = 16'h0000;
		hist_mod_o = 16'h0000;
		core_valid_o = 1'b0;
		core_sample_o = 16'h0000;
	end
	// History then samples; released lines show the inverse value
	always @(posedge clk_sys_i) begin
		if (go_i) begin
			for (int k = 0; k < 16; k++) begin
				hist_valid_o <= 1'b1;
				hist_orig_o <= ORIG;
				hist_mod_o <= MODV;
				@(posedge clk_sys_i);
			end
			hist_valid_o <= 1'b0;
			hist_orig_o <= ~ORIG;
			hist_mod_o <= ~MODV;
			for (int k = 0; k < COUNT; k++) begin
				core_valid_o <= 1'b1;
				core_sample_o <= 16'(BASE + k);
				do @(posedge clk_sys_i); while (core_ready_i !== 1'b1);
			end
			core_valid_o <= 1'b0;
			core_sample_o <= ~core_sample_o;
		end
	end
endmodule

// ---- verification/tb_codec_mode_transition_smoother.sv ----
// Self-checking bench for the mode transition smoother.
// Assumes the smoother, its package and the core model are compiled first.
module tb_codec_mode_transition_smoother;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i, reset_i, frame_start_i, go, core_valid_i, core_ready_o;
	logic hist_valid_i, core_valid_o, out_valid_i, out_ready_o, out_valid_o;
	logic zir_busy_o;
	logic signed [15:0] hist_orig_i, hist_mod_i, core_sample_i, core_sample_o;
	logic signed [15:0] highband_i, out_sample_o;
	logic signed [15:0] coeff_i [16];
	logic [15:0] overlap_len_o;
	mode_smoother_pkg::frame_info_s info_i;
	mode_smoother_pkg::sample_in_s out_sample_i;
	mode_smoother_pkg::core_cmd_s core_cmd_o;
	int err_count = 0;
	int cmp_count = 0;
	// ====
	// Design and far-side model
	mode_transition_smoother #(.CORE_RATE_HZ(12800), .OUT_RATE_HZ(16000),
		.GAP_LEN(64)) mode_transition_smoother_i (.clk_sys_i, .reset_i,
		.frame_start_i, .info_i, .coeff_i, .hist_valid_i, .hist_orig_i,
		.hist_mod_i, .core_valid_i, .core_sample_i, .core_ready_o,
		.core_valid_o, .core_sample_o, .out_valid_i, .out_sample_i,
		.highband_i, .out_ready_o, .out_valid_o, .out_sample_o, .core_cmd_o,
		.overlap_len_o, .zir_busy_o);
	core_src_model core_src_model_i (.clk_sys_i, .go_i(go),
		.core_ready_i(core_ready_o), .hist_valid_o(hist_valid_i),
		.hist_orig_o(hist_orig_i), .hist_mod_o(hist_mod_i),
		.core_valid_o(core_valid_i), .core_sample_o(core_sample_i));
	// ====
	// Common tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic start_frame(input mode_smoother_pkg::coding_mode_e c,
		input mode_smoother_pkg::coding_mode_e p,
		input mode_smoother_pkg::variant_e v);
		@(posedge clk_sys_i);
		frame_start_i <= 1'b1;
		info_i <= '{cur_mode: c, prev_mode: p, variant: v, out_rate_8k: 1'b0};
		@(posedge clk_sys_i);
		frame_start_i <= 1'b0;
		#1;
	endtask
	// One output-rate transfer; result read once the answer has landed
	task automatic send_out(input mode_smoother_pkg::sample_in_s s,
		output logic signed [15:0] seen);
		@(posedge clk_sys_i);
		out_valid_i <= 1'b1;
		out_sample_i <= s;
		do @(posedge clk_sys_i); while (out_ready_o !== 1'b1);
		out_valid_i <= 1'b0;
		out_sample_i <= ~s;
		#1;
		check(out_valid_o, 1'b1);
		seen = out_sample_o;
	endtask
	// ====
	// Scenarios
	task automatic t_reset();
		@(posedge clk_sys_i);
		#1;
		check({core_valid_o, out_valid_o, core_cmd_o}, 32'h0000_0000);
		check(overlap_len_o, 16'h0010);
	endtask
	// Transform alone, then blend, then predictive alone over 320 samples
	task automatic t_dual();
		logic signed [15:0] y;
		start_frame(mode_smoother_pkg::predictive_mode,
			mode_smoother_pkg::transform_excitation_mode,
			mode_smoother_pkg::dual_rate_transition_variant);
		check(core_cmd_o.dual_rate_update, 1'b1);
		check(core_cmd_o.zero_pad_low_rate, 1'b0);
		for (int n = 0; n < 320; n++) begin
			send_out('{16'h1000, 16'h0200, 16'h0000, 16'h0000}, y);
			if (n < 4) check(y, 16'h1000);
			else if (n >= 37) check(y, 16'h0200);
			else check(y inside {[16'h0200:16'h1000]}, 1'b1);
		end
	endtask
	// Previous synthesis for D samples, then predictive plus aliased memory
	task automatic run_d(input mode_smoother_pkg::variant_e v);
		logic signed [15:0] y;
		logic [15:0] al;
		start_frame(mode_smoother_pkg::predictive_mode,
			mode_smoother_pkg::high_quality_transform_mode, v);
		if (v == mode_smoother_pkg::reset_transition_variant)
			check(core_cmd_o[8:5], 4'hF);
		else
			check({core_cmd_o.zero_memories, core_cmd_o.extrapolate_memories},
				2'h3);
		for (int n = 0; n < 10; n++) begin
			al = (n == 4) ? 16'h0020 : 16'h0000;
			send_out('{16'h0E00, 16'h0100, 16'h0700, al}, y);
			check(y, n < 4 ? 16'h0700 : 16'h0100 + al);
		end
	endtask
	// Ringing from a constant difference of 0x40 decays by (64-n)/64
	task automatic t_zir();
		int w;
		logic signed [15:0] y;
		start_frame(mode_smoother_pkg::transform_excitation_mode,
			mode_smoother_pkg::predictive_mode, mode_smoother_pkg::no_transition);
		check(core_cmd_o.lengthen_transform, 1'b1);
		check(core_ready_o, 1'b0);
		@(posedge clk_sys_i);
		go <= 1'b1;
		@(posedge clk_sys_i);
		go <= 1'b0;
		for (int k = 0; k < 70; k++) begin
			w = 0;
			do begin
				@(posedge clk_sys_i);
				#1;
				w++;
			end while (core_valid_o !== 1'b1 && w < 300);
			check(w < 300, 1'b1);
			check(core_sample_o, 16'(16'h0300 + k + (k < 64 ? 64 - k : 0)));
		end
		// First output-rate sample: response start plus full high band
		highband_i <= 16'h0010;
		send_out('{16'h0E00, 16'h0100, 16'h0000, 16'h0000}, y);
		check(y, 16'h0E50);
		highband_i <= 16'h0000;
	endtask
	// ====
	// Clock, main sequence and watchdog
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		reset_i = 1'b1;
		frame_start_i = 1'b0;
		info_i = '0;
		out_valid_i = 1'b0;
		out_sample_i = '0;
		highband_i = 16'h0000;
		go = 1'b0;
		foreach (coeff_i[m]) coeff_i[m] = (m == 0) ? 16'hF000 : 16'h0000;
		repeat (12) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		t_reset();
		t_dual();
		run_d(mode_smoother_pkg::reset_transition_variant);
		run_d(mode_smoother_pkg::mixed_transition_variant);
		t_zir();
		wrap_up();
	end
	initial begin
		#(8 * 20000);
		err_count++;
		wrap_up();
	end
endmodule
bind mode_transition_smoother mode_smoother_chk #(.CORE_RATE_HZ(CORE_RATE_HZ))
	chk_i (.clk_sys_i, .reset_i, .frame_start_i, .info_i, .core_valid_i,
	.core_ready_o, .core_valid_o, .out_valid_i, .out_ready_o, .out_valid_o,
	.core_cmd_o, .overlap_len_o, .zir_busy_o);
